// *** bench/mpsc_carrier_model.sv ***
// Carrier board model: pull-ups, button, straps and force-off watch
`timescale 1ns/1ps
`default_nettype none
module mpsc_carrier_model #(
    parameter int BLANK_CYC = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_oe,
    input wire logic foff_oe,
    input wire logic reset_val,
    input wire logic foff_val,
    input wire logic press,
    input wire logic rst_pull,
    input wire logic rec_pull,
    input wire logic wake_pull,
    output logic btn_n,
    output logic rst_in_n,
    output logic rec_n,
    output logic wake_n,
    output logic reset_wire,
    output logic foff_wire,
    output var logic supply_cut
);
    int blank_cnt;
    // Open-drain lines rest high through pull-ups
    assign btn_n = !press;
    assign rst_in_n = !rst_pull;
    assign rec_n = !rec_pull;
    assign wake_n = !wake_pull;
    assign reset_wire = !(reset_oe && !reset_val);
    assign foff_wire = !(foff_oe && !foff_val);
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blank_cnt <= 0;
            supply_cut <= 1'h0;
        end else if (blank_cnt < BLANK_CYC) begin
            blank_cnt <= blank_cnt + 1;
        end else if (!foff_wire) begin
            supply_cut <= 1'h1;
        end
    end
endmodule : mpsc_carrier_model
`default_nettype wire

// *** bench/tb.sv ***
// Testbench of the module power-state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb import mpsc_pkg::*;;
    localparam int LONG = 20;
    localparam int RAMP = 8;
    localparam int HOLD = 4;
    logic clk, rstn, press, rst_pull, rec_pull, wake_pull;
    logic btn_n, rst_in_n, rec_n, wake_n, reset_wire, foff_wire, supply_cut;
    logic pwr_en, sleep_en, rst_o, rst_oe, foff_o, foff_oe;
    mpsc_soc_in_t soc_in;
    mpsc_soc_out_t soc_out;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    mpsc_top #(.LONG_PRESS_CYC(LONG), .RAMP_CYC(RAMP), .RESET_HOLD_CYC(HOLD)) i_dut (
        .clk(clk), .rstn(rstn), .module_reset_in_n(rst_in_n), .power_button_in_n(btn_n),
        .recovery_strap_n(rec_n), .wake_input_n(wake_n), .soc_in(soc_in), .soc_out(soc_out),
        .carrier_power_enable(pwr_en), .sleep_rail_enable_n(sleep_en),
        .carrier_reset_out_n(rst_o), .carrier_reset_out_oe(rst_oe),
        .force_off_request_n(foff_o), .force_off_request_oe(foff_oe));
    mpsc_carrier_model #(.BLANK_CYC(16)) i_carrier (
        .clk(clk), .rstn(rstn), .reset_oe(rst_oe), .foff_oe(foff_oe), .press(press),
        .reset_val(rst_o), .foff_val(foff_o),
        .rst_pull(rst_pull), .rec_pull(rec_pull), .wake_pull(wake_pull), .btn_n(btn_n),
        .rst_in_n(rst_in_n), .rec_n(rec_n), .wake_n(wake_n), .reset_wire(reset_wire),
        .foff_wire(foff_wire), .supply_cut(supply_cut));
    initial begin
        clk = 1'h0;
        forever #4 clk = !clk;
    end
    task end_sim;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            $display("BAD %0t timeout", $time);
            end_sim();
        end
    end
    function automatic logic [3:0] outs();
        return {pwr_en, sleep_en, rst_oe, foff_oe};
    endfunction : outs
    task automatic chk(logic [3:0] exp, string msg);
        tests_run++;
        if (outs() !== exp) begin
            error_cnt++;
            $display("BAD %0t %s: outputs %b", $time, msg, outs());
        end
    endtask : chk
    task automatic chk1(logic got, logic exp, string msg);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk1
    task automatic cycles(int n);
        repeat (n) @(negedge clk);
    endtask : cycles
    task automatic wait_outs(logic [3:0] exp, int max, string msg);
        int n;
        n = 0;
        while (outs() !== exp && n < max) begin
            @(negedge clk);
            n++;
        end
        chk(exp, msg);
    endtask : wait_outs
    task automatic tap(int n);
        press = 1'h1;
        cycles(n);
        press = 1'h0;
    endtask : tap
    task automatic power_up(logic rec);
        rstn = 1'h0;
        rec_pull = rec;
        cycles(20);
        chk(4'h2, "no supply");
        chk1(soc_out.system_reset_n, 1'h0, "reset in no supply");
        rstn = 1'h1;
        cycles(1);
        chk(4'hA, "ramp");
        wait_outs(4'hC, RAMP + 4, "run after supply");
        chk1(soc_out.recovery_mode, rec, "recovery mode");
        chk1(soc_out.system_reset_n, 1'h1, "system out of reset");
        chk1(reset_wire, 1'h1, "reset wire released");
        chk1(soc_out.rails_on, 1'h1, "rails on when running");
        rec_pull = 1'h0;
        $display("power-up done");
    endtask : power_up
    task automatic t_irq;
        int seen;
        seen = 0;
        tap(5);
        repeat (8) begin
            @(negedge clk);
            if (soc_out.button_irq === 1'h1) seen++;
        end
        chk1(seen == 1, 1'h1, "one interrupt pulse");
        chk(4'hC, "state kept on short press");
        $display("short press done");
    endtask : t_irq
    task automatic t_sleep(int src);
        soc_in.suspend_req = 1'h1;
        cycles(1);
        soc_in.suspend_req = 1'h0;
        chk(4'h8, "sleep");
        chk1(reset_wire, 1'h1, "no reset entering sleep");
        case (src)
            0: soc_in.rtc_wake = 1'h1;
            1: soc_in.periph_wake = 1'h1;
            2: soc_in.gpio_wake = 1'h1;
            3: tap(3);
            default: begin
                wake_pull = 1'h1;
                cycles(8);
                chk(4'h8, "wake pin disabled");
                chk1(reset_wire, 1'h1, "no reset during sleep");
                soc_in.wake_enable = 1'h1;
            end
        endcase
        wait_outs(4'hC, 10, "wake");
        chk1(reset_wire, 1'h1, "no reset leaving sleep");
        soc_in = '0;
        wake_pull = 1'h0;
        cycles(12);
        $display("sleep with source %0d done", src);
    endtask : t_sleep
    task automatic t_carrier_reset;
        rst_pull = 1'h1;
        wait_outs(4'h2, 6, "carrier reset");
        cycles(30);
        chk(4'h2, "reset held");
        chk1(reset_wire, 1'h0, "reset wire low");
        rst_pull = 1'h0;
        wait_outs(4'hA, HOLD + 6, "ramp after reset");
        wait_outs(4'hC, RAMP + 4, "run after reset");
        $display("carrier reset done");
    endtask : t_carrier_reset
    task automatic t_cold;
        soc_in.reset_req = 1'h1;
        cycles(1);
        soc_in.reset_req = 1'h0;
        chk(4'h2, "cold reset");
        chk1(soc_out.rails_on, 1'h0, "rails off in cold reset");
        wait_outs(4'hC, HOLD + RAMP + 6, "run after cold reset");
        $display("cold reset done");
    endtask : t_cold
    task automatic t_long;
        press = 1'h1;
        cycles(LONG - 2);
        chk(4'hC, "not yet off");
        wait_outs(4'h3, 8, "off on long press");
        chk1(foff_wire, 1'h0, "force-off low");
        chk1(reset_wire, 1'h0, "reset low when off");
        press = 1'h0;
        cycles(8);
        chk(4'h3, "release keeps off");
        chk1(supply_cut, 1'h1, "carrier saw force-off");
        tap(3);
        wait_outs(4'hA, 8, "restart");
        wait_outs(4'hC, RAMP + 4, "run after restart");
        $display("long press done");
    endtask : t_long
    initial begin
        rstn = 1'h0;
        press = 1'h0;
        rst_pull = 1'h0;
        rec_pull = 1'h0;
        wake_pull = 1'h0;
        soc_in = '0;
        @(negedge clk);
        power_up(1'h0);
        t_irq();
        for (int s = 0; s < 5; s++) t_sleep(s);
        t_carrier_reset();
        t_cold();
        t_long();
        power_up(1'h1);
        end_sim();
    end
endmodule : tb
`default_nettype wire

// *** include/mpsc_cfg.svh ***
// Constants of the module power-state sequencer
`ifndef MPSC_CFG_SVH
`define MPSC_CFG_SVH
`define MPSC_CLK_MHZ 125
`define MPSC_LONG_PRESS_MS 5000
`define MPSC_RAMP_US 2000
`define MPSC_RESET_HOLD_US 100
`define MPSC_FORCE_OFF_BLANK_MS 400
`define MPSC_CNT_W 32
`define MPSC_PIN_RST 0
`define MPSC_PIN_BTN 1
`define MPSC_PIN_REC 2
`define MPSC_PIN_WAKE 3
`define MPSC_PIN_N 4
`endif

// *** include/mpsc_pkg.sv ***
// Types of the module power-state sequencer
`include "mpsc_cfg.svh"
package mpsc_pkg;
    typedef enum logic [2:0] {
        MPSC_ST_RESET,
        MPSC_ST_RAMP,
        MPSC_ST_RUN,
        MPSC_ST_SLEEP,
        MPSC_ST_OFF
    } mpsc_state_t;

    typedef struct packed {
        logic suspend_req;
        logic reset_req;
        logic wake_enable;
        logic rtc_wake;
        logic periph_wake;
        logic gpio_wake;
    } mpsc_soc_in_t;

    typedef struct packed {
        logic system_reset_n;
        logic rails_on;
        logic button_irq;
        logic recovery_mode;
    } mpsc_soc_out_t;

    typedef struct packed {
        mpsc_state_t state;
        logic [`MPSC_PIN_N-1:0] pin_s1;
        logic [`MPSC_PIN_N-1:0] pin_s2;
        logic [`MPSC_CNT_W-1:0] press_cnt;
        logic [`MPSC_CNT_W-1:0] tmr;
        logic recovery;
        logic irq;
        logic pwr_en;
        logic sleep_en;
        logic rst_drive;
        logic foff_drive;
    } mpsc_regs_t;
endpackage : mpsc_pkg

// *** rtl/mpsc_top.sv ***
// Power-state sequencer of a plug-in computer module
`timescale 1ns/1ps
`default_nettype none
`include "mpsc_cfg.svh"
module mpsc_top
    import mpsc_pkg::*;
#(
    parameter int unsigned LONG_PRESS_CYC = `MPSC_LONG_PRESS_MS * 1000 * `MPSC_CLK_MHZ,
    parameter int unsigned RAMP_CYC = `MPSC_RAMP_US * `MPSC_CLK_MHZ,
    parameter int unsigned RESET_HOLD_CYC = `MPSC_RESET_HOLD_US * `MPSC_CLK_MHZ
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic module_reset_in_n,
    input wire logic power_button_in_n,
    input wire logic recovery_strap_n,
    input wire logic wake_input_n,
    input wire mpsc_soc_in_t soc_in,
    output var mpsc_soc_out_t soc_out,
    output logic carrier_power_enable,
    output logic sleep_rail_enable_n,
    output logic carrier_reset_out_n,
    output logic carrier_reset_out_oe,
    output logic force_off_request_n,
    output logic force_off_request_oe
);
    localparam logic [`MPSC_CNT_W-1:0] LONG_C = `MPSC_CNT_W'(LONG_PRESS_CYC);
    localparam logic [`MPSC_CNT_W-1:0] RAMP_C = `MPSC_CNT_W'(RAMP_CYC);
    localparam logic [`MPSC_CNT_W-1:0] HOLD_C = `MPSC_CNT_W'(RESET_HOLD_CYC);
    localparam logic [`MPSC_CNT_W-1:0] ONE_C = `MPSC_CNT_W'(1);
    localparam logic [`MPSC_CNT_W-1:0] ZERO_C = `MPSC_CNT_W'(0);

    mpsc_regs_t r_reg;
    mpsc_regs_t r_next;

    logic rst_in_low;
    logic btn_held;
    logic short_press;
    logic long_press;
    logic wake_any;

    always_comb begin
        r_next = r_reg;
        // Pin synchronisers, second stage only is read
        r_next.pin_s1 = {wake_input_n, recovery_strap_n, power_button_in_n, module_reset_in_n};
        r_next.pin_s2 = r_reg.pin_s1;
        rst_in_low = !r_reg.pin_s2[`MPSC_PIN_RST];
        btn_held = !r_reg.pin_s2[`MPSC_PIN_BTN];
        // Press length, saturating at the long threshold
        if (!btn_held) begin
            r_next.press_cnt = ZERO_C;
        end else if (r_reg.press_cnt != LONG_C) begin
            r_next.press_cnt = r_reg.press_cnt + ONE_C;
        end
        short_press = !btn_held && r_reg.press_cnt != ZERO_C && r_reg.press_cnt != LONG_C;
        long_press = btn_held && r_reg.press_cnt == LONG_C - ONE_C;
        wake_any = soc_in.rtc_wake || soc_in.periph_wake || soc_in.gpio_wake
            || short_press
            || (soc_in.wake_enable && !r_reg.pin_s2[`MPSC_PIN_WAKE]);
        r_next.irq = 1'h0;
        if (r_reg.tmr != ZERO_C) begin
            r_next.tmr = r_reg.tmr - ONE_C;
        end
        if (rst_in_low) begin
            r_next.state = MPSC_ST_RESET;
            r_next.tmr = HOLD_C;
        end else begin
            case (r_reg.state)
                MPSC_ST_RESET: begin
                    if (r_reg.tmr == ZERO_C) begin
                        r_next.state = MPSC_ST_RAMP;
                        r_next.tmr = RAMP_C;
                    end
                end
                MPSC_ST_RAMP: begin
                    if (long_press) begin
                        r_next.state = MPSC_ST_OFF;
                    end else if (r_reg.tmr == ZERO_C) begin
                        r_next.state = MPSC_ST_RUN;
                        r_next.recovery = !r_reg.pin_s2[`MPSC_PIN_REC];
                    end
                end
                MPSC_ST_RUN: begin
                    if (long_press) begin
                        r_next.state = MPSC_ST_OFF;
                    end else if (soc_in.reset_req) begin
                        r_next.state = MPSC_ST_RESET;
                        r_next.tmr = HOLD_C;
                    end else if (soc_in.suspend_req) begin
                        r_next.state = MPSC_ST_SLEEP;
                    end else if (short_press) begin
                        r_next.irq = 1'h1;
                    end
                end
                MPSC_ST_SLEEP: begin
                    if (long_press) begin
                        r_next.state = MPSC_ST_OFF;
                    end else if (wake_any) begin
                        r_next.state = MPSC_ST_RUN;
                    end
                end
                MPSC_ST_OFF: begin
                    if (short_press) begin
                        r_next.state = MPSC_ST_RAMP;
                        r_next.tmr = RAMP_C;
                    end
                end
                default: begin
                    r_next.state = MPSC_ST_RESET;
                    r_next.tmr = HOLD_C;
                end
            endcase
        end
        // Pin levels follow the coming state
        r_next.pwr_en = r_next.state == MPSC_ST_RAMP || r_next.state == MPSC_ST_RUN
            || r_next.state == MPSC_ST_SLEEP;
        r_next.sleep_en = r_next.state == MPSC_ST_RUN;
        r_next.rst_drive = !(r_next.state == MPSC_ST_RUN
            || r_next.state == MPSC_ST_SLEEP);
        // Force-off only in off, never during the blanked power-up
        r_next.foff_drive = r_next.state == MPSC_ST_OFF;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // No supply: enables low, start power-up on release
            r_reg.state <= MPSC_ST_RAMP;
            r_reg.pin_s1 <= {`MPSC_PIN_N{1'h1}};
            r_reg.pin_s2 <= {`MPSC_PIN_N{1'h1}};
            r_reg.press_cnt <= ZERO_C;
            r_reg.tmr <= RAMP_C;
            r_reg.recovery <= 1'h0;
            r_reg.irq <= 1'h0;
            r_reg.pwr_en <= 1'h0;
            r_reg.sleep_en <= 1'h0;
            r_reg.rst_drive <= 1'h1;
            r_reg.foff_drive <= 1'h0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign carrier_power_enable = r_reg.pwr_en;
    assign sleep_rail_enable_n = r_reg.sleep_en;
    assign carrier_reset_out_n = 1'h0;
    assign carrier_reset_out_oe = r_reg.rst_drive;
    assign force_off_request_n = 1'h0;
    assign force_off_request_oe = r_reg.foff_drive;
    assign soc_out.system_reset_n = !r_reg.rst_drive;
    assign soc_out.rails_on = r_reg.pwr_en;
    assign soc_out.button_irq = r_reg.irq;
    assign soc_out.recovery_mode = r_reg.recovery;

    property p_sleep_no_reset;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_SLEEP || $past(r_reg.state) == MPSC_ST_SLEEP
            |-> !carrier_reset_out_oe || r_reg.state == MPSC_ST_RESET
            || r_reg.state == MPSC_ST_OFF;
    endproperty
    a_sleep_no_reset: assert property (p_sleep_no_reset)
        else $error("reset output asserted around sleep");

    property p_sleep_power;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_SLEEP |-> carrier_power_enable && !sleep_rail_enable_n;
    endproperty
    a_sleep_power: assert property (p_sleep_power)
        else $error("power enable not held in sleep");

    property p_suspend_rail;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RUN && soc_in.suspend_req && !rst_in_low && !long_press
            && !soc_in.reset_req |=> !sleep_rail_enable_n && r_reg.state == MPSC_ST_SLEEP;
    endproperty
    a_suspend_rail: assert property (p_suspend_rail)
        else $error("sleep rail not dropped on suspend");

    property p_reset_in;
        @(posedge clk) disable iff (!rstn)
        !module_reset_in_n ##1 !module_reset_in_n ##1 !module_reset_in_n
            |=> r_reg.state == MPSC_ST_RESET && !carrier_power_enable;
    endproperty
    a_reset_in: assert property (p_reset_in)
        else $error("module reset input not obeyed");

    property p_long_press;
        @(posedge clk) disable iff (!rstn)
        long_press && !rst_in_low && r_reg.state != MPSC_ST_RESET
            |=> r_reg.state == MPSC_ST_OFF;
    endproperty
    a_long_press: assert property (p_long_press)
        else $error("long press did not shut down");

    property p_short_off;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_OFF && short_press && !rst_in_low
            |=> r_reg.state == MPSC_ST_RAMP && carrier_power_enable;
    endproperty
    a_short_off: assert property (p_short_off)
        else $error("short press did not power up");

    property p_run_irq;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RUN && short_press && !rst_in_low && !soc_in.reset_req
            && !soc_in.suspend_req |=> soc_out.button_irq && r_reg.state == MPSC_ST_RUN
            ##1 !soc_out.button_irq;
    endproperty
    a_run_irq: assert property (p_run_irq)
        else $error("running short press handled wrongly");

    property p_recovery;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RAMP && r_reg.tmr == ZERO_C && !rst_in_low && !long_press
            |=> soc_out.recovery_mode == !$past(r_reg.pin_s2[`MPSC_PIN_REC]);
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("recovery strap not captured");

    property p_wake_input;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_SLEEP && !rst_in_low && !long_press
            && soc_in.wake_enable && !r_reg.pin_s2[`MPSC_PIN_WAKE]
            |=> r_reg.state == MPSC_ST_RUN && sleep_rail_enable_n;
    endproperty
    a_wake_input: assert property (p_wake_input)
        else $error("wake input ignored in sleep");

    property p_off_pins;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_OFF |-> !carrier_power_enable && !sleep_rail_enable_n
            && carrier_reset_out_oe && force_off_request_oe;
    endproperty
    a_off_pins: assert property (p_off_pins)
        else $error("off state pins wrong");

    property p_cold_reset;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RESET |-> !carrier_power_enable && !soc_out.rails_on
            && !sleep_rail_enable_n && carrier_reset_out_oe;
    endproperty
    a_cold_reset: assert property (p_cold_reset)
        else $error("cold reset left rails on");

    property p_ramp_done;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RAMP && r_reg.tmr == ZERO_C && !rst_in_low && !long_press
            |=> r_reg.state == MPSC_ST_RUN && !carrier_reset_out_oe;
    endproperty
    a_ramp_done: assert property (p_ramp_done)
        else $error("power-up did not reach running");

    property p_run_pins;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RUN |-> carrier_power_enable && sleep_rail_enable_n
            && !carrier_reset_out_oe && !force_off_request_oe;
    endproperty
    a_run_pins: assert property (p_run_pins)
        else $error("running state pins wrong");

    property p_rail_only_run;
        @(posedge clk) disable iff (!rstn)
        sleep_rail_enable_n |-> r_reg.state == MPSC_ST_RUN;
    endproperty
    a_rail_only_run: assert property (p_rail_only_run)
        else $error("sleep rail high outside running");

    property p_reset_hold;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_RESET && rst_in_low |=> r_reg.state == MPSC_ST_RESET;
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset state left while reset input low");

    property p_button_wake;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_SLEEP && short_press && !rst_in_low && !long_press
            |=> r_reg.state == MPSC_ST_RUN;
    endproperty
    a_button_wake: assert property (p_button_wake)
        else $error("short press did not wake from sleep");

    property p_soc_wake;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_SLEEP && !rst_in_low && !long_press
            && (soc_in.rtc_wake || soc_in.periph_wake || soc_in.gpio_wake)
            |=> r_reg.state == MPSC_ST_RUN && sleep_rail_enable_n;
    endproperty
    a_soc_wake: assert property (p_soc_wake)
        else $error("internal wake source ignored in sleep");

    property p_irq_in_run;
        @(posedge clk) disable iff (!rstn)
        soc_out.button_irq |-> r_reg.state == MPSC_ST_RUN
            && $past(r_reg.state) == MPSC_ST_RUN;
    endproperty
    a_irq_in_run: assert property (p_irq_in_run)
        else $error("button interrupt outside running");

    property p_off_stays;
        @(posedge clk) disable iff (!rstn)
        r_reg.state == MPSC_ST_OFF && !short_press && !rst_in_low
            |=> r_reg.state == MPSC_ST_OFF;
    endproperty
    a_off_stays: assert property (p_off_stays)
        else $error("off state left without short press");
endmodule : mpsc_top
`default_nettype wire
